// ===== design/ahpms_host_port.sv
// host port and mode selection of a six-converter sampling device
// assumes all host pins are asynchronous; the converter core sits on
// the system clock and hands results over in offset binary
`timescale 1ns/1ps
// Overview of operation
// R01 - standby input low stops all converters
// R02 - hardware mode: pair triggers pick sampled pairs
// R03 - software mode: control register picks sampled pairs
// R04 - serial interface: only pair-a trigger starts conversions
// R05 - word mode uses all sixteen bus lines
// R06 - byte mode: upper eight lines, line 7 selects byte
// R07 - host reads twice per result in byte mode
// R08 - host grounds word/byte select in serial use
// R09 - chip select and read low drive result out
// R10 - chip select and write low load control
// R11 - results presented in twos complement
// R12 - byte select level picks upper or lower half
module ahpms_host_port (
  input  wire logic                         I_CLK_SYS,        // 40 MHz system clock
  input  wire logic                         I_RESET,          // sync, active high
  input  wire logic                         I_STANDBY_N,      // low puts converters to standby
  input  wire logic                         I_HW_SW_SEL,      // 0 hardware, 1 software select
  input  wire logic                         I_SERIAL_SEL,     // 1 serial interface in use
  input  wire logic                         I_WORD_BYTE,      // 0 word, 1 byte transfers
  input  wire logic                         I_CS_N,           // chip select
  input  wire logic                         I_RD_N,           // read strobe
  input  wire logic                         I_WR_N,           // write strobe
  input  wire logic [ahpms_pkg::PAIR_N-1:0] I_PAIR_TRIGGER,   // pair triggers a=0, b=1, c=2
  input  wire logic [ahpms_pkg::BUS_W-1:0]  I_BUS_LINE,       // bus lines, input side
  input  wire logic                         I_RESULT_VALID,   // core result strobe
  input  wire logic [ahpms_pkg::CHAN_W-1:0] I_RESULT_CHAN,    // core result channel
  input  wire logic [ahpms_pkg::BUS_W-1:0]  I_RESULT_DATA,    // core result, offset binary
  output logic      [ahpms_pkg::BUS_W-1:0]  O_BUS_LINE,       // bus lines, output side
  output logic      [ahpms_pkg::BUS_W-1:0]  O_BUS_LINE_OE,    // per-line drive enable
  output logic      [ahpms_pkg::PAIR_N-1:0] O_PAIR_START,     // one-cycle start to core pairs
  output logic                              O_BUSY,           // conversion in progress
  output logic                              O_STANDBY,        // converters held in standby
  output logic      [ahpms_pkg::BUS_W-1:0]  O_CTRL            // control register contents
);
  import ahpms_pkg::*;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_W = 7 + PAIR_N + BUS_W;  // bundled pin count
  logic [SYNC_W-1:0] meta_q;   // first stage, read only by sync_q
  logic [SYNC_W-1:0] sync_q;   // second stage, safe to use

  // every host pin passes two flops before use
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      meta_q <= {{4{1'b0}}, 3'h7, {PAIR_N{1'b0}}, {BUS_W{1'b0}}};
      sync_q <= {{4{1'b0}}, 3'h7, {PAIR_N{1'b0}}, {BUS_W{1'b0}}};
    end else begin
      meta_q <= {I_STANDBY_N, I_HW_SW_SEL, I_SERIAL_SEL, I_WORD_BYTE,
                 I_CS_N, I_RD_N, I_WR_N, I_PAIR_TRIGGER, I_BUS_LINE};
      sync_q <= meta_q;
    end
  end

  logic              run_s;      // standby input, synced
  logic              sw_mode_s;  // software select mode
  logic              serial_s;   // serial interface in use
  logic              byte_s;     // byte mode requested
  logic              cs_n_s;     // chip select
  logic              rd_n_s;     // read strobe
  logic              wr_n_s;     // write strobe
  logic [PAIR_N-1:0] trig_s;     // pair triggers
  logic [BUS_W-1:0]  bus_s;      // bus lines in
  assign {run_s, sw_mode_s, serial_s, byte_s, cs_n_s, rd_n_s, wr_n_s, trig_s, bus_s} = sync_q;

  // ----------------------------------------------------------------
  // strobe decode and edge detection
  // ----------------------------------------------------------------
  logic              rd_act;     // read cycle active on parallel port
  logic              wr_act;     // write cycle active on parallel port
  logic              byte_mode;  // byte mode only with parallel port
  logic              high_byte_enable;       // high byte enable level
  logic              rd_act_q;   // previous read state
  logic              wr_act_q;   // previous write state
  logic [PAIR_N-1:0] trig_q;     // previous trigger levels
  logic [PAIR_N-1:0] trig_rise;  // trigger rising edges

  assign rd_act    = !serial_s && !cs_n_s && !rd_n_s;  // [R09]
  assign wr_act    = !serial_s && !cs_n_s && !wr_n_s;  // [R10]
  assign byte_mode = byte_s && !serial_s;              // [R06]
  assign high_byte_enable      = bus_s[HIGH_BYTE_ENABLE_BIT];                  // [R06]
  assign trig_rise = trig_s & ~trig_q;

  // strobe and trigger history
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      trig_q   <= '0;
    end else begin
      rd_act_q <= rd_act;
      wr_act_q <= wr_act;
      trig_q   <= trig_s;
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  logic [BUS_W-1:0] ctrl_q;  // host-written control word

  // loaded while the write strobe is held; byte mode fills one half
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_act) begin  // [R10]
      if (!byte_mode) begin
        ctrl_q <= bus_s;
      end else if (high_byte_enable) begin
        ctrl_q[BUS_W-1:BYTE_W] <= bus_s[BUS_W-1:BYTE_W];
      end else begin
        ctrl_q[BYTE_W-1:0] <= bus_s[BUS_W-1:BYTE_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // conversion start and busy timing
  // ----------------------------------------------------------------
  logic [PAIR_N-1:0] ctrl_pairs;  // pairs picked by software
  logic [PAIR_N-1:0] start_d;     // pairs to start this cycle
  logic [CNT_W-1:0]  busy_cnt_q;  // cycles left in conversion

  assign ctrl_pairs = ctrl_q[CTRL_SEL_LSB +: PAIR_N];

  // start set; triggers are dropped while busy or in standby
  always_comb begin
    start_d = '0;
    if (run_s && (busy_cnt_q == '0)) begin  // [R01]
      if (serial_s) begin
        // only the pair-a edge opens a conversion here
        if (trig_rise[0]) begin  // [R04]
          start_d = sw_mode_s ? ctrl_pairs : (trig_s | 3'h1);
        end
      end else if (sw_mode_s) begin
        if (|trig_rise) begin
          start_d = ctrl_pairs;  // [R03]
        end
      end else begin
        start_d = trig_rise;  // [R02]
      end
    end
  end

  // start pulses to the core and the busy window
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      O_PAIR_START <= '0;
      busy_cnt_q   <= '0;
      O_BUSY       <= 1'b0;
    end else begin
      O_PAIR_START <= start_d;
      if (|start_d) begin
        busy_cnt_q <= CONV_CNT;
      end else if (busy_cnt_q != '0) begin
        busy_cnt_q <= busy_cnt_q - 1'b1;
      end
      O_BUSY <= (|start_d) || (busy_cnt_q > 8'h01);
    end
  end

  // standby flag and control mirror
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      O_STANDBY <= 1'b0;
      O_CTRL    <= CTRL_RESET;
    end else begin
      O_STANDBY <= !run_s;  // [R01]
      O_CTRL    <= ctrl_q;
    end
  end

  // ----------------------------------------------------------------
  // result store and read pointer
  // ----------------------------------------------------------------
  logic [CHAN_W-1:0] rd_chan_q;  // channel presented to the host
  logic [BUS_W-1:0]  mem_rdata;  // registered word from the store
  logic [BUS_W-1:0]  result_tc;  // core word in twos complement
  logic              rd_end;     // read cycle just finished

  // offset binary to twos complement by flipping the sign bit
  assign result_tc = {~I_RESULT_DATA[BUS_W-1], I_RESULT_DATA[BUS_W-2:0]};  // [R11]
  assign rd_end    = rd_act_q && !rd_act;

  ahpms_result_mem u_mem (
    .i_clk   (I_CLK_SYS),
    .i_we    (I_RESULT_VALID),
    .i_waddr (I_RESULT_CHAN),
    .i_wdata (result_tc),
    .i_raddr (rd_chan_q),
    .o_rdata (mem_rdata)
  );

  // pointer restarts at each conversion; in byte mode it moves on
  // only after the low-byte read, so two reads make one result
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      rd_chan_q <= CHAN_FIRST;
    end else if (|start_d) begin
      rd_chan_q <= CHAN_FIRST;
    end else if (rd_end && (!byte_mode || !high_byte_enable)) begin  // [R07]
      rd_chan_q <= (rd_chan_q == CHAN_LAST) ? CHAN_FIRST : rd_chan_q + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // bus drive
  // ----------------------------------------------------------------
  // serial use leaves every line undriven, as the lines are grounded there
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      O_BUS_LINE    <= '0;
      O_BUS_LINE_OE <= '0;
    end else if (rd_act && !byte_mode) begin
      O_BUS_LINE    <= mem_rdata;  // [R05]
      O_BUS_LINE_OE <= 16'hffff;   // [R09]
    end else if (rd_act) begin
      // line 7 stays an input for the byte select
      O_BUS_LINE    <= {(high_byte_enable ? mem_rdata[BUS_W-1:BYTE_W] : mem_rdata[BYTE_W-1:0]),
                        8'h00};  // [R12]
      O_BUS_LINE_OE <= 16'hff00;  // [R06]
    end else begin
      O_BUS_LINE    <= '0;
      O_BUS_LINE_OE <= '0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RESET);

  sequence s_trig_a_serial;
    serial_s && trig_rise[0] && run_s && (busy_cnt_q == '0);
  endsequence
  sequence s_start_window;
    ##1 (|O_PAIR_START) ##1 O_BUSY;
  endsequence

  standby_no_start_a: assert property (!run_s |=> O_PAIR_START == '0)  // [R01]
    else $error("start issued during standby");
  hw_pairs_follow_a: assert property (!serial_s && !sw_mode_s && run_s
      && busy_cnt_q == '0 |=> O_PAIR_START == $past(trig_rise))  // [R02]
    else $error("hardware start does not follow triggers");
  sw_pairs_ctrl_a: assert property (!serial_s && sw_mode_s && run_s && busy_cnt_q == '0
      && (|trig_rise) |=> O_PAIR_START == $past(ctrl_pairs))  // [R03]
    else $error("software start does not follow control");
  serial_trig_a_a: assert property (serial_s && !trig_rise[0] |=> O_PAIR_START == '0)  // [R04]
    else $error("serial start without pair-a trigger");
  serial_start_seq_a: assert property ((s_trig_a_serial and (sw_mode_s ? (|ctrl_pairs) : 1'b1))
      |-> s_start_window)  // [R04]
    else $error("pair-a trigger did not start conversion");
  word_drive_a: assert property (rd_act && !byte_mode |=> O_BUS_LINE_OE == 16'hffff
      && O_BUS_LINE == $past(mem_rdata))  // [R05]
    else $error("word read not on full bus");
  byte_lanes_a: assert property (rd_act && byte_mode |=> O_BUS_LINE_OE == 16'hff00
      && O_BUS_LINE[7:0] == 8'h00)  // [R06]
    else $error("byte read drives low lines");
  byte_half_a: assert property (rd_act && byte_mode && !high_byte_enable
      |=> O_BUS_LINE[15:8] == $past(mem_rdata[7:0]))  // [R12]
    else $error("low byte not presented");
  idle_release_a: assert property (!rd_act |=> O_BUS_LINE_OE == '0)  // [R09]
    else $error("bus driven outside a read");
  ctrl_load_a: assert property (wr_act && !byte_mode |=> ctrl_q == $past(bus_s))  // [R10]
    else $error("control not loaded on write");
  busy_hold_a: assert property ((|O_PAIR_START) |-> O_BUSY [*8])  // [R04]
    else $error("busy dropped early");
  tc_write_a: assert property (I_RESULT_VALID && I_RESULT_CHAN <= CHAN_LAST
      |=> u_mem.mem_q[$past(I_RESULT_CHAN)] == ($past(I_RESULT_DATA) ^ 16'h8000))  // [R11]
    else $error("stored result not in twos complement");
endmodule

// ===== design/ahpms_pkg.sv
// package of constants for the converter host port mode-select block
// assumes one 40 MHz system clock; no other file defines these values
package ahpms_pkg;
  // ----------------------------------------------------------------
  // bus and channel geometry
  // ----------------------------------------------------------------
  localparam int unsigned BUS_W     = 16;          // parallel bus width
  localparam int unsigned BYTE_W    = 8;           // byte-mode lane width
  localparam int unsigned PAIR_N    = 3;           // converter pairs a, b, c
  localparam int unsigned CHAN_N    = 6;           // converters, two per pair
  localparam int unsigned CHAN_W    = 3;           // channel index width
  localparam int unsigned HIGH_BYTE_ENABLE_BIT  = 7;           // line that acts as byte select
  // ----------------------------------------------------------------
  // control register layout
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_SEL_LSB = 13;       // pair-select field, bits 15:13
  localparam logic [BUS_W-1:0] CTRL_RESET = 16'h0000;  // control value after reset
  localparam logic [CHAN_W-1:0] CHAN_LAST = 3'h5;      // last channel before wrap
  localparam logic [CHAN_W-1:0] CHAN_FIRST = 3'h0;     // first channel read out
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 25;      // 40 MHz system clock
  localparam int unsigned CONV_TIME_NS  = 3000;    // conversion time
  localparam int unsigned CONV_CYCLES   = CONV_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 8;       // busy counter width
  localparam logic [CNT_W-1:0] CONV_CNT = CNT_W'(CONV_CYCLES);
endpackage

// ===== design/ahpms_result_mem.sv
// six-word result store for the converter host port
// assumes single clock, write from the converter core, registered read
`timescale 1ns/1ps
module ahpms_result_mem (
  input  wire logic                           i_clk,    // system clock
  input  wire logic                           i_we,     // write strobe
  input  wire logic [ahpms_pkg::CHAN_W-1:0]   i_waddr,  // write channel
  input  wire logic [ahpms_pkg::BUS_W-1:0]    i_wdata,  // write word
  input  wire logic [ahpms_pkg::CHAN_W-1:0]   i_raddr,  // read channel
  output logic      [ahpms_pkg::BUS_W-1:0]    o_rdata   // registered read word
);
  import ahpms_pkg::*;
  logic [BUS_W-1:0] mem_q [CHAN_N];  // one word per converter

  // write port, out-of-range channels dropped
  always_ff @(posedge i_clk) begin
    if (i_we && (i_waddr <= CHAN_LAST)) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  // read port, one cycle of latency
  always_ff @(posedge i_clk) begin
    if (i_raddr <= CHAN_LAST) begin
      o_rdata <= mem_q[i_raddr];
    end else begin
      o_rdata <= '0;
    end
  end
endmodule

// ===== tb/ahpms_host_model.sv
// host bus model: drives chip select, read and write strobes and the data lines
// assumes the bench resolves the shared lines from the device drive enables, host value elsewhere
`timescale 1ns/1ps
module ahpms_host_model (
  input  wire logic        i_clk,       // system clock
  input  wire logic [15:0] i_bus_line,  // resolved bus lines
  input  wire logic [15:0] i_bus_oe,    // device drive enables
  output logic             o_cs_n,      // chip select
  output logic             o_rd_n,      // read strobe
  output logic             o_wr_n,      // write strobe
  output logic      [15:0] o_bus        // host drive value
);
  initial begin
    o_cs_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_bus  = 16'h0000;
  end
  // --------------------------------------------------------------
  // bus cycles
  // --------------------------------------------------------------
  // write: strobes held past the two-flop input sync of the device
  task automatic wr_cycle(input logic [15:0] v);
    @(posedge i_clk);
    o_cs_n <= 1'b0; // both low loads control
    o_wr_n <= 1'b0;
    o_bus  <= v;
    repeat (4) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_wr_n <= 1'b1;
    o_bus  <= ~v; // released lines show the inverse, not the old value
    repeat (3) @(posedge i_clk);
  endtask
  // read: line 7 carries the byte select level in byte mode
  task automatic rd_cycle(input logic high_byte_enable, output logic [15:0] d, output logic [15:0] oe);
    int n;
    @(posedge i_clk);
    o_cs_n <= 1'b0; // both low asks for the result
    o_rd_n <= 1'b0;
    o_bus[7] <= high_byte_enable; // high picks the upper half, low the lower half
    repeat (4) @(posedge i_clk);
    d  = i_bus_line;
    oe = i_bus_oe;
    o_cs_n <= 1'b1;
    o_rd_n <= 1'b1;
    n = 0;
    while (i_bus_oe !== 16'h0000 && n < 10) begin
      @(posedge i_clk);
      n++;
    end
    repeat (2) @(posedge i_clk);
  endtask
endmodule

// ===== tb/tb_adc_host_port_mode_select.sv
// self-checking bench for the converter host port mode-select block
// assumes the host model above and a 40 MHz clock; no random stimulus
`timescale 1ns/1ps
module tb_adc_host_port_mode_select;
  import ahpms_pkg::*;
  `define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t mismatch %h vs %h", $time, a, b); end end
  logic                clk, rst, standby_n_n, hw_sw, ser, wb, rv;
  logic [PAIR_N-1:0]   trig, start;         // pair triggers and start pulses
  logic [CHAN_W-1:0]   rch;                 // core result channel
  logic [BUS_W-1:0]    rdat, bus_out, bus_oe, ctrl, h_bus, bus_in, d, oe;
  logic                cs_n, rd_n, wr_n, busy, standby_n;
  int                  failures, n_compared;
  // wire level: device drives where enabled, host elsewhere
  assign bus_in = (bus_oe & bus_out) | (~bus_oe & h_bus);
  ahpms_host_port uut (.I_CLK_SYS(clk), .I_RESET(rst), .I_STANDBY_N(standby_n_n),
    .I_HW_SW_SEL(hw_sw), .I_SERIAL_SEL(ser), .I_WORD_BYTE(wb), .I_CS_N(cs_n),
    .I_RD_N(rd_n), .I_WR_N(wr_n), .I_PAIR_TRIGGER(trig), .I_BUS_LINE(bus_in),
    .I_RESULT_VALID(rv), .I_RESULT_CHAN(rch), .I_RESULT_DATA(rdat),
    .O_BUS_LINE(bus_out), .O_BUS_LINE_OE(bus_oe), .O_PAIR_START(start),
    .O_BUSY(busy), .O_STANDBY(standby_n), .O_CTRL(ctrl));
  ahpms_host_model host (.i_clk(clk), .i_bus_line(bus_in), .i_bus_oe(bus_oe),
    .o_cs_n(cs_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_bus(h_bus));
  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic complete_run();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // raise pins, expect a start set, then time the busy window
  task automatic pulse(input logic [2:0] pins, input logic [2:0] exp);
    int n;
    logic [2:0] got;
    @(posedge clk) trig <= pins;
    got = 3'h0;
    n = 0;
    while (n < 8 && got === 3'h0) begin
      @(negedge clk);
      got = start;
      n++;
    end
    `CHK(got, exp)
    if (exp !== 3'h0) begin
      n = 0;
      while (busy === 1'b1 && n < 200) begin
        @(negedge clk);
        n++;
      end
      `CHK(n, int'(CONV_TIME_NS / CLK_PERIOD_NS))
    end
    @(posedge clk) trig <= 3'h0;
    repeat (4) @(posedge clk);
  endtask
  // one core result write
  task automatic put(input logic [CHAN_W-1:0] ch, input logic [BUS_W-1:0] v);
    @(posedge clk);
    rv <= 1'b1;
    rch <= ch;
    rdat <= v;
    @(posedge clk) rv <= 1'b0;
  endtask
  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  task automatic t_reset();
    `CHK(bus_oe, 16'h0000)
    `CHK(ctrl, CTRL_RESET)
    `CHK(busy, 1'b0)
    $display("t_reset done");
  endtask
  task automatic t_hw();
    pulse(3'b010, 3'b010); // only the rising pair
    pulse(3'b101, 3'b101); // two pairs together
    $display("t_hw done");
  endtask
  task automatic t_standby();
    @(posedge clk) standby_n_n <= 1'b0;
    repeat (4) @(posedge clk);
    `CHK(standby_n, 1'b1)
    pulse(3'b001, 3'b000); // standby drops the trigger
    @(posedge clk) standby_n_n <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(standby_n, 1'b0)
    pulse(3'b001, 3'b001);
    $display("t_standby done");
  endtask
  task automatic t_soft();
    host.wr_cycle(16'ha000);
    `CHK(ctrl, 16'ha000)
    @(posedge clk) hw_sw <= 1'b1;
    repeat (4) @(posedge clk);
    pulse(3'b010, 3'b101); // pairs come from control bits
    @(posedge clk) hw_sw <= 1'b0;
    $display("t_soft done");
  endtask
  task automatic t_serial();
    @(posedge clk) ser <= 1'b1; // word/byte stays grounded
    repeat (4) @(posedge clk);
    pulse(3'b010, 3'b000); // pair b alone starts nothing
    pulse(3'b011, 3'b011); // pair a starts, b high joins
    host.wr_cycle(16'h0000);
    `CHK(ctrl, 16'ha000) // parallel writes ignored in serial use
    @(posedge clk) hw_sw <= 1'b1;
    repeat (4) @(posedge clk);
    pulse(3'b001, 3'b101); // pair a starts the control pairs
    @(posedge clk) hw_sw <= 1'b0;
    host.rd_cycle(1'b0, d, oe);
    `CHK(oe, 16'h0000) // parallel port silent in serial use
    @(posedge clk) ser <= 1'b0;
    repeat (4) @(posedge clk);
    $display("t_serial done");
  endtask
  task automatic t_read();
    pulse(3'b111, 3'b111); // start resets the read pointer
    put(3'h0, 16'h1234);
    put(3'h1, 16'hc3a5);
    host.rd_cycle(1'b0, d, oe);
    `CHK(oe, 16'hffff)
    `CHK(d, 16'h1234 ^ 16'h8000) // twos complement out
    @(posedge clk) wb <= 1'b1;
    repeat (4) @(posedge clk);
    host.rd_cycle(1'b1, d, oe);
    `CHK(oe, 16'hff00) // upper lines only
    `CHK(d[15:8], 8'hc3 ^ 8'h80) // high half on select high
    host.rd_cycle(1'b0, d, oe);
    `CHK(d[15:8], 8'ha5) // low half completes the word
    `CHK(oe, 16'hff00) // line 7 stays an input
    host.wr_cycle(16'h6080); // line 7 high: upper half of control
    host.wr_cycle(16'h5a00); // line 7 low: lower half of control
    `CHK(ctrl, 16'h605a) // byte writes fill both halves
    @(posedge clk) wb <= 1'b0;
    $display("t_read done");
  endtask
  // --------------------------------------------------------------
  // clock, watchdog, main sequence
  // --------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    failures++; // hang cut short
    complete_run();
  end
  initial begin
    failures = 0;
    n_compared = 0;
    rst = 1'b1;
    standby_n_n = 1'b1;
    hw_sw = 1'b0;
    ser = 1'b0;
    wb = 1'b0;
    rv = 1'b0;
    trig = 3'h0;
    rch = 3'h0;
    rdat = 16'h0000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset();
    t_hw();
    t_standby();
    t_soft();
    t_serial();
    t_read();
    complete_run();
  end
endmodule
